// ===== bst_jtag_host.sv
/*
  Behavioural scan test controller that drives the pins of the port.
  Assumes it alone drives the scan pins and uses a 400 ns scan clock.
*/
module bst_jtag_host #(
  parameter int W = 297
) (
  // Scan pins towards the device
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstN,
  // Scan data back from the device and its drive enable
  input wire logic tdo,
  input wire logic tdoEn
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins at rest; the clock is parked low between frames
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    trstN = 1'h0;
  end

  // Test reset low, then released well before the next clock edge
  task automatic pulse_reset();
    trstN = 1'h0;
    #400;
    trstN = 1'h1;
    #400;
  endtask : pulse_reset

  // One scan clock: pins move while it is low, data is taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #200;
    tck = 1'h1;
    // Released line floats to its pull-up level
    o = tdoEn ? tdo : 1'h1;
    #200;
    tck = 1'h0;
  endtask : step

  // Mode-select path, first step in bit 0
  task automatic walk(input logic [7:0] path, input int n);
    logic o;
    for (int i = 0; i < n; i++)
      step(path[i], 1'h1, o);
  endtask : walk

  // Shift n bits; the last one leaves the shift state with mode-select high
  task automatic shift(input int n, input logic [W-1:0] din, output logic [W-1:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
  endtask : shift

  // Instruction scan from idle back to idle
  task automatic ir_scan(input logic [3:0] code, output logic [3:0] cap);
    logic [W-1:0] q;
    walk(8'h03, 4);
    shift(4, W'(code), q);
    cap = q[3:0];
    walk(8'h01, 2);
  endtask : ir_scan

  // Full-length data scan from idle back to idle
  // Top bit goes first so din lands in register order; read-back is put in order too
  task automatic dr_scan(input logic [W-1:0] din, output logic [W-1:0] dout);
    logic [W-1:0] fin;
    logic [W-1:0] fout;
    for (int i = 0; i < W; i++)
      fin[i] = din[W-1-i];
    walk(8'h01, 3);
    shift(W, fin, fout);
    for (int i = 0; i < W; i++)
      dout[i] = fout[W-1-i];
    walk(8'h01, 2);
  endtask : dr_scan

endmodule : bst_jtag_host

// ===== bst_pin_sync.sv
/*
  Two-stage synchroniser for the scan pins.
  Assumes the pins are asynchronous to clk; the first stage is only
  read by the second stage.
*/
module bst_pin_sync #(
  parameter int WIDTH = bst_pkg::PIN_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pins
  input wire logic [WIDTH-1:0] pinIn,
  // Synchronised pins
  output logic [WIDTH-1:0] pinOut
);

  // Both stages of every bit
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bst_sync_s;

  bst_sync_s s;
  bst_sync_s next_s;

  // One stage pair per pin bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        next_s.meta[i] = pinIn[i];
        next_s.stable[i] = s.meta[i];
      end
    end
  endgenerate

  // Registers; reset to zero keeps the controller held in reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pinOut = s.stable;

endmodule : bst_pin_sync

// ===== bst_pkg.sv
/*
  Shared constants and types of the boundary-scan test access port:
  instruction codes, register lengths, controller states and the
  synchronised pin bundle.
  Assumes a single core clock domain that samples all scan pins.
*/
package bst_pkg;

  // Instruction register length
  localparam int IR_LEN = 4;
  // Boundary scan chain length
  localparam int BSR_LEN = 297;
  // Consecutive mode-select highs that force the reset state
  localparam int RESET_ONES = 5;
  // Width of the saturating counter of mode-select highs
  localparam int ONES_W = 3;

  // Instruction codes
  localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;
  // Fixed pattern loaded into the instruction shift stage on capture
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

  // Clock figures: core clock and slowest bench scan clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int TCK_PERIOD_NS = 400;
  // Core clocks per scan clock period
  localparam int TCK_CLKS = TCK_PERIOD_NS / CLK_PERIOD_NS;

  // Controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } bst_tap_e;

  // Scan pins as they arrive at the block
  typedef struct packed {
    logic trstN;
    logic tdi;
    logic tms;
    logic tck;
  } bst_pins_s;

  localparam int PIN_W = $bits(bst_pins_s);

endpackage : bst_pkg

// ===== bst_tap.sv
/*
  Boundary-scan test access port: sixteen-state controller, four-bit
  instruction register, one-bit bypass and the boundary scan chain.
  Assumes the scan clock is much slower than clk (at least four core
  clocks per half period) and that the pad-side vector padIn is
  produced by core logic on clk.
*/
// Behaviour
// - Four-bit instruction register with shift stage
// - Decode extest, sample/preload, bypass codes
// - Instruction enters least significant bit first
// - One-bit bypass captures zero, drives output
// - Boundary chain is 297 serial cells
// - Input to chain LSB, output from MSB
// - Sample on rising, change output on falling
// - All scan activity follows scan clock only; test reset and the reset-state defaults act on clk without it
// - Test reset low forces reset state
// - Five mode-select highs reach reset state
// - Reset state: stay on 1, idle on 0
// - Reset state clears chain most significant cell
// - Idle: stay on 0, select-DR on 1
// - Select-DR: capture on 0, select-IR on 1
// - Select-IR: capture on 0, reset on 1
// - Capture-DR loads selected register, then moves
// - Shift-DR shifts one bit per clock
// - Exit1-DR: pause on 0, update on 1
// - Pause-DR holds both registers
// - Exit2-DR: shift on 0, update on 1
// - Output latch updates in Update-DR; reset state clears its top cell
// - Capture-IR loads pattern 0001
// - Shift-IR shifts instruction; Exit1-IR branches
// - Pause-IR holds; Exit2-IR branches
// - Update-IR latches the active instruction
module bst_tap #(
  parameter int BSR_W = bst_pkg::BSR_LEN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Scan pins from the tester
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  // Scan data out and its drive enable
  output logic tdo,
  output logic tdoEn,
  // Pad ring side
  input wire logic [BSR_W-1:0] padIn,
  output logic [BSR_W-1:0] padOut,
  output logic extestMode,
  output logic tapInReset
);

  // Whole state of the port
  typedef struct packed {
    bst_pkg::bst_tap_e tap;                 // Controller state
    logic [bst_pkg::IR_LEN-1:0] irShift;    // Instruction shift stage
    logic [bst_pkg::IR_LEN-1:0] irActive;   // Active instruction
    logic bypassBit;                        // Bypass register
    logic [BSR_W-1:0] bsrShift;             // Chain shift stage
    logic [BSR_W-1:0] bsrLatch;             // Chain output latch
    logic tckLast;                          // Scan clock one clk ago
    logic tdoBit;                           // Registered output bit
    logic tdoDrive;                         // Registered output enable
    logic [bst_pkg::ONES_W-1:0] ones;       // Mode-select highs seen
  } bst_tap_s;

  bst_tap_s s;
  bst_tap_s next_s;

  // Synchronised pins
  bst_pkg::bst_pins_s pinRaw;
  bst_pkg::bst_pins_s pinSync;

  // Scan clock edges seen by clk
  logic tckRise;
  logic tckFall;
  // Chain selected by the active instruction
  logic selBsr;
  // Serial bit offered to the output
  logic serialOut;

  assign pinRaw = '{trstN: trstN, tdi: tdi, tms: tms, tck: tck};

  // All scan pins cross into clk before use
  bst_pin_sync #(
    .WIDTH(bst_pkg::PIN_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  // Edges; every scan action but test reset and the reset-state defaults waits for one of these
  assign tckRise = pinSync.tck && !s.tckLast;
  assign tckFall = !pinSync.tck && s.tckLast;

  // Only the two chain instructions pick the chain; all else is bypass
  assign selBsr = (s.irActive == bst_pkg::IR_EXTEST) ||
                  (s.irActive == bst_pkg::IR_SAMPLE);

  // Next controller state for a given mode-select bit
  function automatic bst_pkg::bst_tap_e tapStep(
    input bst_pkg::bst_tap_e cur,
    input logic m
  );
    bst_pkg::bst_tap_e nxt;
    nxt = cur;
    case (cur)
      // Stay while high, go idle on low
      bst_pkg::TEST_LOGIC_RESET:
        nxt = m ? bst_pkg::TEST_LOGIC_RESET : bst_pkg::RUN_TEST_IDLE;
      bst_pkg::RUN_TEST_IDLE:
        nxt = m ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      bst_pkg::SELECT_DR:
        nxt = m ? bst_pkg::SELECT_IR : bst_pkg::CAPTURE_DR;
      bst_pkg::CAPTURE_DR:
        nxt = m ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
      bst_pkg::SHIFT_DR:
        nxt = m ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
      bst_pkg::EXIT1_DR:
        nxt = m ? bst_pkg::UPDATE_DR : bst_pkg::PAUSE_DR;
      bst_pkg::PAUSE_DR:
        nxt = m ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
      bst_pkg::EXIT2_DR:
        nxt = m ? bst_pkg::UPDATE_DR : bst_pkg::SHIFT_DR;
      bst_pkg::UPDATE_DR:
        nxt = m ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      // A high here escapes back to reset
      bst_pkg::SELECT_IR:
        nxt = m ? bst_pkg::TEST_LOGIC_RESET : bst_pkg::CAPTURE_IR;
      bst_pkg::CAPTURE_IR:
        nxt = m ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
      bst_pkg::SHIFT_IR:
        nxt = m ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
      bst_pkg::EXIT1_IR:
        nxt = m ? bst_pkg::UPDATE_IR : bst_pkg::PAUSE_IR;
      bst_pkg::PAUSE_IR:
        nxt = m ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
      bst_pkg::EXIT2_IR:
        nxt = m ? bst_pkg::UPDATE_IR : bst_pkg::SHIFT_IR;
      bst_pkg::UPDATE_IR:
        nxt = m ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      default:
        nxt = bst_pkg::TEST_LOGIC_RESET;
    endcase
    return nxt;
  endfunction : tapStep

  // Bit presented on the output: IR low end, bypass, or chain top
  always_comb
  begin
    if (s.tap == bst_pkg::SHIFT_IR)
    begin
      serialOut = s.irShift[0];
    end
    else if (selBsr)
    begin
      serialOut = s.bsrShift[BSR_W-1];
    end
    else
    begin
      serialOut = s.bypassBit;
    end
  end

  // Next-state logic of the whole port
  always_comb
  begin
    next_s = s;
    next_s.tckLast = pinSync.tck;
    // Rising edge: sample inputs, step controller, act on state
    if (tckRise)
    begin
      next_s.tap = tapStep(s.tap, pinSync.tms);
      // Count highs; five of them from anywhere end in reset
      if (!pinSync.tms)
      begin
        next_s.ones = '0;
      end
      else if (s.ones != bst_pkg::ONES_W'(bst_pkg::RESET_ONES))
      begin
        next_s.ones = s.ones + 1'b1;
      end
      case (s.tap)
        // Fixed pattern lets the tester check the register works
        bst_pkg::CAPTURE_IR:
        begin
          next_s.irShift = bst_pkg::IR_CAPTURE;
        end
        // New bit enters the top, oldest leaves from bit 0
        bst_pkg::SHIFT_IR:
        begin
          next_s.irShift = {pinSync.tdi, s.irShift[bst_pkg::IR_LEN-1:1]};
        end
        bst_pkg::UPDATE_IR:
        begin
          next_s.irActive = s.irShift;
        end
        // Chain takes the pads; bypass loads a fixed zero
        bst_pkg::CAPTURE_DR:
        begin
          if (selBsr)
          begin
            next_s.bsrShift = padIn;
          end
          else
          begin
            next_s.bypassBit = 1'b0;
          end
        end
        bst_pkg::SHIFT_DR:
        begin
          if (selBsr)
          begin
            next_s.bsrShift = {s.bsrShift[BSR_W-2:0], pinSync.tdi};
          end
          else
          begin
            next_s.bypassBit = pinSync.tdi;
          end
        end
        // Pads see new data here and, top cell only, in reset state; never mid-shift
        bst_pkg::UPDATE_DR:
        begin
          if (selBsr)
          begin
            next_s.bsrLatch = s.bsrShift;
          end
        end
        // Idle, select, exit and pause states hold registers
        default:
        begin
          next_s.bypassBit = s.bypassBit;
        end
      endcase
    end
    // Falling edge: only moment the output may change
    if (tckFall)
    begin
      next_s.tdoBit = serialOut;
      next_s.tdoDrive = (s.tap == bst_pkg::SHIFT_IR) ||
                        (s.tap == bst_pkg::SHIFT_DR);
    end
    // Reset state: bypass active, top cell cleared to disable its pin
    if (s.tap == bst_pkg::TEST_LOGIC_RESET)
    begin
      next_s.irActive = bst_pkg::IR_BYPASS;
      next_s.bsrShift[BSR_W-1] = 1'b0;
      next_s.bsrLatch[BSR_W-1] = 1'b0;
    end
    // Test reset pin overrides everything; output released at once
    if (!pinSync.trstN)
    begin
      next_s.tap = bst_pkg::TEST_LOGIC_RESET;
      next_s.tdoDrive = 1'b0;
    end
  end

  // State register; core reset parks the port in reset state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '{tap: bst_pkg::TEST_LOGIC_RESET,
             irShift: bst_pkg::IR_CAPTURE,
             irActive: bst_pkg::IR_BYPASS,
             default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from registers
  assign tdo = s.tdoBit;
  assign tdoEn = s.tdoDrive;
  assign padOut = s.bsrLatch;
  assign extestMode = (s.irActive == bst_pkg::IR_EXTEST);
  assign tapInReset = (s.tap == bst_pkg::TEST_LOGIC_RESET);

  // Checks on the port's own behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Rising edge seen with a given state
  sequence seqRiseIn(bst_pkg::bst_tap_e st);
    tckRise && pinSync.trstN && s.tap == st;
  endsequence

  // Rising edge in Shift-IR with the chain otherwise idle
  sequence seqShiftIr;
    seqRiseIn(bst_pkg::SHIFT_IR);
  endsequence

  // Rising edge in Shift-DR with the chain selected
  sequence seqShiftChain;
    seqRiseIn(bst_pkg::SHIFT_DR) ##0 selBsr;
  endsequence

  AST_RESET_STAYS: assert property (
    seqRiseIn(bst_pkg::TEST_LOGIC_RESET) ##0 pinSync.tms
      |=> s.tap == bst_pkg::TEST_LOGIC_RESET
  ) else $error("Reset state left while mode-select high");

  AST_FIVE_ONES: assert property (
    s.ones == bst_pkg::ONES_W'(bst_pkg::RESET_ONES)
      |-> s.tap == bst_pkg::TEST_LOGIC_RESET
  ) else $error("Five highs did not reach reset state");

  AST_TRST_FORCES: assert property (
    !pinSync.trstN |=> s.tap == bst_pkg::TEST_LOGIC_RESET && !tdoEn
  ) else $error("Test reset pin did not force reset state");

  AST_IR_LSB_FIRST: assert property (
    seqShiftIr |=> s.irShift[bst_pkg::IR_LEN-1] == $past(pinSync.tdi)
      && s.irShift[bst_pkg::IR_LEN-2:0] == $past(s.irShift[bst_pkg::IR_LEN-1:1])
  ) else $error("Instruction shift direction wrong");

  AST_IR_CAPTURE: assert property (
    seqRiseIn(bst_pkg::CAPTURE_IR) |=> s.irShift == bst_pkg::IR_CAPTURE
  ) else $error("Capture pattern not loaded");

  AST_IR_UPDATE: assert property (
    seqRiseIn(bst_pkg::UPDATE_IR) |=> s.irActive == $past(s.irShift)
  ) else $error("Instruction not latched on update");

  AST_CHAIN_SHIFT: assert property (
    seqShiftChain |=> s.bsrShift[0] == $past(pinSync.tdi)
      && s.bsrShift[BSR_W-1] == $past(s.bsrShift[BSR_W-2])
  ) else $error("Chain did not shift from low end");

  AST_LATCH_ONLY_UPDATE: assert property (
    !(tckRise && s.tap == bst_pkg::UPDATE_DR) &&
      s.tap != bst_pkg::TEST_LOGIC_RESET |=> $stable(padOut)
  ) else $error("Output latch moved outside update");

  AST_TDO_ON_FALL: assert property (
    $changed(tdo) |-> $past(tckFall)
  ) else $error("Output changed away from falling edge");

  AST_TDO_ONLY_SHIFT: assert property (
    tckFall && pinSync.trstN && s.tap != bst_pkg::SHIFT_IR
      && s.tap != bst_pkg::SHIFT_DR |=> !tdoEn
  ) else $error("Output driven outside shift states");

  AST_RESET_BYPASS: assert property (
    s.tap == bst_pkg::TEST_LOGIC_RESET ##1 s.tap == bst_pkg::TEST_LOGIC_RESET
      |-> s.irActive == bst_pkg::IR_BYPASS && !padOut[BSR_W-1]
  ) else $error("Reset state did not select bypass and clear top cell");

  AST_BYPASS_PATH: assert property (
    tckFall && pinSync.trstN && s.tap == bst_pkg::SHIFT_DR && !selBsr
      |=> tdo == $past(s.bypassBit) && tdoEn
  ) else $error("Bypass bit not presented on output");

endmodule : bst_tap

// ===== tb_boundary_scan_tap.sv
/*
  Self-checking bench of the test access port: instruction table loop,
  then pause, test reset and mode-select reset cases.
  Assumes the scan host model drives all scan pins.
*/
module tb_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int W = bst_pkg::BSR_LEN;

  // Instruction, expected extest flag, chain selected
  typedef struct packed {
    logic [3:0] code;
    logic ext;
    logic chain;
  } bst_row_s;

  logic clk, rst, tck, tms, tdi, trstN, tdo, tdoEn, extestMode, tapInReset;
  logic [W-1:0] padIn, padOut, expPad, pat, got;
  logic [3:0] cap;
  logic o;
  int miscompares = 0;
  int cmpCount = 0;
  // Reserved codes mixed among the documented ones
  bst_row_s rows [6] = '{'{4'h2, 1'h0, 1'h0}, '{4'hF, 1'h0, 1'h0}, '{4'h1, 1'h0, 1'h1},
    '{4'h7, 1'h0, 1'h0}, '{4'hE, 1'h0, 1'h0}, '{4'h0, 1'h1, 1'h1}};

  // Device under test
  bst_tap #(.BSR_W(W)) uut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdo(tdo), .tdoEn(tdoEn), .padIn(padIn), .padOut(padOut),
    .extestMode(extestMode), .tapInReset(tapInReset));

  // Scan host on the far side
  bst_jtag_host #(.W(W)) host (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo),
    .tdoEn(tdoEn));

  // Four-state compare; an unknown matches only an unknown in the same bit
  task automatic check(input string name, input logic [W-1:0] exp, input logic [W-1:0] act);
    cmpCount++;
    if (act !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, act);
    end
  endtask : check

  // Single end of run
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Core clock, 50 ns
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Watchdog, about two and a half times the expected run
  initial
  begin
    #2_000_000;
    miscompares++;
    give_verdict();
  end

  // Main sequence; every pin change lands on a falling core clock edge
  initial
  begin
    rst = 1'h1;
    padIn = {27{11'h5a3}};
    expPad = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    host.pulse_reset();
    check("tapInReset", W'(1'h1), W'(tapInReset));
    check("tdoEn", W'(1'h0), W'(tdoEn));
    host.walk(8'h00, 1);
    check("idle", W'(1'h0), W'(tapInReset));
    // Table loop: load code, then a full data scan
    foreach (rows[r])
    begin
      host.ir_scan(rows[r].code, cap);
      check("irCapture", W'(4'h1), W'(cap));
      check("extestMode", W'(rows[r].ext), W'(extestMode));
      pat = {99{3'(r + 1)}};
      host.dr_scan(pat, got);
      check("drOut", rows[r].chain ? padIn : {1'h0, pat[W-1:1]}, got);
      if (rows[r].chain)
        expPad = pat;
      check("padOut", expPad, padOut);
    end
    // Bypass scan with a pause: held bit must survive a data input held low
    host.ir_scan(4'hF, cap);
    host.walk(8'h01, 3);
    host.step(1'h0, 1'h0, o);
    check("bypassCapture", W'(1'h0), W'(o));
    host.step(1'h1, 1'h1, o);
    host.step(1'h0, 1'h0, o);
    host.step(1'h0, 1'h0, o);
    check("tdoEnPause", W'(1'h0), W'(tdoEn));
    host.step(1'h1, 1'h0, o);
    host.step(1'h0, 1'h0, o);
    host.step(1'h1, 1'h0, o);
    check("pauseHold", W'(1'h1), W'(o));
    check("tdoEnShift", W'(1'h1), W'(tdoEn));
    host.walk(8'h01, 2);
    // Test reset in mid data scan under extest
    host.ir_scan(4'h0, cap);
    host.walk(8'h01, 3);
    host.step(1'h0, 1'h0, o);
    host.pulse_reset();
    check("trstState", W'(1'h1), W'(tapInReset));
    check("trstInstr", W'(1'h0), W'(extestMode));
    check("trstTdoEn", W'(1'h0), W'(tdoEn));
    check("msbCleared", {1'h0, expPad[W-2:0]}, padOut);
    // Mode-select reset from inside an instruction shift
    host.walk(8'h00, 1);
    host.walk(8'h03, 4);
    host.walk(8'h0F, 4);
    check("fourOnes", W'(1'h0), W'(tapInReset));
    host.walk(8'h01, 1);
    check("fiveOnes", W'(1'h1), W'(tapInReset));
    host.walk(8'h01, 1);
    check("stayReset", W'(1'h1), W'(tapInReset));
    host.walk(8'h00, 1);
    check("leaveReset", W'(1'h0), W'(tapInReset));
    give_verdict();
  end

endmodule : tb_boundary_scan_tap
